// ===== src/ssp_pkg.sv
// constants, types and state record of the sync serial port controller
package ssp_pkg;
  // register byte addresses
  localparam logic [7:0] IFLG_ADR = 8'h0C;
  localparam logic [7:0] BUF_ADR = 8'h10;
  localparam logic [7:0] CTRL_ADR = 8'h14;
  localparam logic [7:0] OWN_ADR = 8'h90;
  localparam logic [7:0] STAT_ADR = 8'h94;
  // port_control fields
  localparam int WRITE_COLLISION_BIT = 7;
  localparam int OV_BIT = 6;
  localparam int EN_BIT = 5;
  localparam int CKP_BIT = 4;
  // port_status fields
  localparam int SMP_BIT = 7;
  localparam int CKE_BIT = 6;
  // port_mode_select codes
  localparam logic [3:0] M_DIV4 = 4'h0;
  localparam logic [3:0] M_DIV16 = 4'h1;
  localparam logic [3:0] M_DIV64 = 4'h2;
  localparam logic [3:0] M_TIMER2_OUTPUT = 4'h3;
  localparam logic [3:0] M_SLV_SS = 4'h4;
  localparam logic [3:0] M_SLV_NOSS = 4'h5;
  localparam logic [3:0] M_I2C7 = 4'h6;
  localparam logic [3:0] M_I2C10 = 4'h7;
  localparam logic [3:0] M_I2CFW = 4'hB;
  localparam logic [3:0] M_I2C7SP = 4'hE;
  localparam logic [3:0] M_I2C10SP = 4'hF;
  // half bit periods in clk cycles for osc/4, /16, /64
  localparam logic [5:0] HALF4 = 6'h02;
  localparam logic [5:0] HALF16 = 6'h08;
  localparam logic [5:0] HALF64 = 6'h20;
  localparam logic [4:0] SPI_EDGES = 5'h10;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  typedef enum logic [1:0] {I_IDLE, I_RCV, I_XMT} i2c_st_t;
  typedef struct packed {
    logic sck;
    logic sdi;
    logic ss_n;
    logic sda;
  } pins_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;
  typedef struct packed {
    logic [31:0] dat;
    logic ack;
    logic [7:0] ctl;
    logic [7:0] own;
    logic input_sample_phase, cke, dna, stp, sta, rnw, ua, bf, intf;
    logic [7:0] sbuf;
    logic [7:0] rx;
    logic [7:0] tx;
    pins_t s1, s2, s3;
    logic [5:0] div;
    logic [4:0] edges;
    logic [3:0] bits;
    logic busy, pend, sck_lvl, sdo;
    i2c_st_t ist;
    logic addr_ph, addr2, sda_lo;
    logic o_sck, o_sck_oe, o_sdo_oe, o_sda, o_sda_oe, o_taken;
  } st_t;
  localparam st_t ST_RST = '0;
endpackage

// ===== src/sync_serial_port_ctrl.sv
// sync serial port: spi master/slave and i2c slave behind a wishbone slave
// How it works
// - master samples input at end of output time if phase bit set, else middle
// - shift-out edge follows clock edge bit, swapped for idle-high polarity
// - i2c data/address bit shows whether last byte was data or address
// - stop-seen set on stop; cleared by reset, disable or start
// - start-seen set on start; cleared by reset, disable or stop
// - direction bit of last matching address held until start, stop or ack
// - ten-bit i2c raises address-update when own address must be rewritten
// - receive completion sets buffer-full; cleared when buffer empties
// - i2c transmit keeps buffer-full set until byte shifted out
// - buffer write during transmission sets write-collision; software clears it
// - spi overflow flagged when byte arrives with buffer full; new byte dropped
// - spi overflow only in slave mode, never in master mode
// - i2c overflow on byte into full buffer; software clears overflow
// - spi port enable hands clock, data-out and data-in pins to port
// - i2c port enable hands data and clock pins to port
// - spi clock idles at the clock polarity level
// - i2c holds clock low while polarity bit is zero
// - modes 0000-0011 give spi master at osc/4, /16, /64, timer2/2
// - modes 0100/0101 give spi slave with and without slave select
// - modes 0110/0111 i2c slave 7/10-bit, 1011 firmware master
// - modes 1110/1111 i2c slave plus start/stop interrupts
// - address byte not acknowledged while buffer-full or overflow set
// - port interrupt flag set for every byte; software clears it
module sync_serial_port_ctrl
  import ssp_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, high
  input wire wb_req_t wb_i, // wishbone request
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone ack
  input wire logic timer2_tick_i, // timer2 output pulse
  input wire pins_t pins_i, // raw pin levels
  output logic sck_o, // clock pin level
  output logic sck_oe_o, // clock pin drive enable
  output logic sdo_o, // spi data out
  output logic sdo_oe_o, // spi data out enable
  output logic sda_o, // i2c data level (low)
  output logic sda_oe_o, // i2c data drive enable
  output logic pins_taken_o // pins belong to port
);
  st_t q, n;
  logic en, master, slave, i2c, i2c_slv, tenbit, sp_irq, slv_sel;
  logic acc, wr, rd, bufwr, txbusy, tick, spi_edge, edge_rise, is_tx;
  logic done_m, done_s, scl_r, scl_f, start_c, stop_c, byte_end, match;
  logic [3:0] mode;
  logic [5:0] half;
  logic [7:0] rdata;

  function automatic logic [7:0] shl(input logic [7:0] v, input logic b);
    return {v[6:0], b};
  endfunction

  // mode decode
  // mode select decode
  assign mode = q.ctl[3:0];
  assign en = q.ctl[EN_BIT];
  assign master = mode <= M_TIMER2_OUTPUT;
  assign slave = mode == M_SLV_SS || mode == M_SLV_NOSS;
  assign i2c_slv = mode == M_I2C7 || mode == M_I2C10 || mode == M_I2C7SP || mode == M_I2C10SP;
  assign i2c = i2c_slv || mode == M_I2CFW;
  assign tenbit = mode == M_I2C10 || mode == M_I2C10SP;
  assign sp_irq = mode == M_I2C7SP || mode == M_I2C10SP || mode == M_I2CFW;
  assign slv_sel = mode == M_SLV_NOSS || !q.s2.ss_n;

  // wishbone decode: write and read side effects at the acked edge
  assign acc = wb_i.cyc && wb_i.stb;
  assign wr = acc && q.ack && wb_i.we && wb_i.sel[0];
  assign rd = acc && q.ack && !wb_i.we;
  assign bufwr = wr && wb_i.adr == BUF_ADR;
  assign txbusy = master ? q.busy : slave ? q.edges != 5'h00 : q.ist == I_XMT && q.bf;

  // master bit clock divider
  // rate selection
  assign half = mode == M_DIV4 ? HALF4 : mode == M_DIV16 ? HALF16 : HALF64;
  assign tick = en && q.busy && master &&
                (mode == M_TIMER2_OUTPUT ? timer2_tick_i : q.div == half - 6'h01);

  // spi edge source and direction
  // transmit edge polarity
  assign spi_edge = master ? tick && q.edges < SPI_EDGES
                           : en && slave && slv_sel && (q.s2.sck ^ q.s3.sck);
  assign edge_rise = master ? !q.sck_lvl : q.s2.sck;
  assign is_tx = edge_rise == (q.cke ^ q.ctl[CKP_BIT]);
  assign done_m = tick && q.edges == SPI_EDGES;
  assign done_s = en && slave && spi_edge && !is_tx && q.bits == LAST_BIT;

  // i2c line events from synchronised levels
  assign scl_r = q.s2.sck && !q.s3.sck;
  assign scl_f = !q.s2.sck && q.s3.sck;
  assign start_c = q.s2.sck && q.s3.sck && q.s3.sda && !q.s2.sda;
  assign stop_c = q.s2.sck && q.s3.sck && !q.s3.sda && q.s2.sda;
  assign byte_end = en && i2c && scl_f && q.ist != I_IDLE && q.bits == LAST_BIT;
  assign match = q.addr2 ? q.rx == q.own : q.rx[7:1] == q.own[7:1];

  // register read mux
  always_comb begin
    unique case (wb_i.adr)
      CTRL_ADR: rdata = q.ctl;
      STAT_ADR: rdata = {q.input_sample_phase, q.cke, q.dna, q.stp, q.sta, q.rnw, q.ua, q.bf};
      BUF_ADR: rdata = q.sbuf;
      OWN_ADR: rdata = q.own;
      IFLG_ADR: rdata = {7'h00, q.intf};
      default: rdata = 8'h00;
    endcase
  end

  // next state
  always_comb begin
    n = q;
    n.s1 = pins_i;
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.ack = acc && !q.ack;
    if (acc && !q.ack) begin
      n.dat = {24'h000000, rdata};
    end
    // software writes first, so hardware sets below win
    if (wr) begin
      unique case (wb_i.adr)
        CTRL_ADR: n.ctl = wb_i.dat[7:0];
        STAT_ADR: begin
          n.input_sample_phase = wb_i.dat[SMP_BIT];
          n.cke = wb_i.dat[CKE_BIT];
        end
        OWN_ADR: begin
          n.own = wb_i.dat[7:0];
          n.ua = 1'b0;
        end
        IFLG_ADR: n.intf = q.intf && wb_i.dat[0];
        default: ;
      endcase
    end
    if (rd && wb_i.adr == BUF_ADR) begin
      n.bf = 1'b0;
    end
    // buffer write: collision or load
    if (bufwr) begin
      if (txbusy) begin
        n.ctl[WRITE_COLLISION_BIT] = 1'b1;
      end else begin
        n.sbuf = wb_i.dat[7:0];
        n.tx = wb_i.dat[7:0];
        if (i2c) begin
          if (q.ist == I_XMT) begin
            n.bf = 1'b1;
            n.sda_lo = !wb_i.dat[7];
            n.tx = shl(wb_i.dat[7:0], 1'b0);
            n.bits = 4'h0;
          end
        end else begin
          n.busy = 1'b1;
          n.edges = 5'h00;
          n.bits = 4'h0;
          n.div = 6'h00;
          n.pend = 1'b0;
          if (!q.cke) begin
            n.sdo = wb_i.dat[7];
            n.tx = shl(wb_i.dat[7:0], 1'b0);
          end
        end
      end
    end
    // spi master clock
    if (master && q.busy) begin
      n.div = tick ? 6'h00 : q.div + 6'h01;
    end else if (master) begin
      n.sck_lvl = q.ctl[CKP_BIT];
    end
    // delayed sample at end of output time
    if (tick && q.pend) begin
      n.rx = shl(q.rx, q.s2.sdi);
      n.bits = q.bits + 4'h1;
      n.pend = 1'b0;
    end
    if (spi_edge) begin
      n.edges = q.edges + 5'h01;
      if (master) begin
        n.sck_lvl = !q.sck_lvl;
      end
      if (is_tx) begin
        n.sdo = q.tx[7];
        n.tx = shl(q.tx, 1'b0);
      end else if (q.input_sample_phase && master) begin
        n.pend = 1'b1;
      end else begin
        n.rx = shl(q.rx, q.s2.sdi);
        n.bits = q.bits + 4'h1;
      end
    end
    if (slave && !slv_sel) begin
      n.edges = 5'h00;
      n.bits = 4'h0;
    end
    if (done_m || done_s) begin
      n.busy = 1'b0;
      n.edges = 5'h00;
      n.bits = 4'h0;
      n.intf = 1'b1;
      if (slave && q.bf) begin
        n.ctl[OV_BIT] = 1'b1;
      end else begin
        n.sbuf = n.rx;
        n.bf = 1'b1;
      end
    end
    // i2c engine
    if (en && i2c) begin
      if (start_c) begin
        n.sta = 1'b1;
        n.stp = 1'b0;
        n.rnw = 1'b0;
        n.ist = i2c_slv ? I_RCV : I_IDLE;
        n.addr_ph = 1'b1;
        n.addr2 = 1'b0;
        n.bits = 4'h0;
        n.sda_lo = 1'b0;
        n.intf = q.intf || sp_irq;
      end else if (stop_c) begin
        n.stp = 1'b1;
        n.sta = 1'b0;
        n.rnw = 1'b0;
        n.ist = I_IDLE;
        n.sda_lo = 1'b0;
        n.intf = q.intf || sp_irq;
      end else if (scl_r && q.ist == I_RCV && q.bits < ACK_BIT) begin
        n.rx = shl(q.rx, q.s2.sda);
      end else if (scl_r && q.ist == I_XMT && q.bits == ACK_BIT && q.s2.sda) begin
        n.ist = I_IDLE;
      end else if (byte_end) begin
        n.bits = ACK_BIT;
        n.intf = 1'b1;
        if (q.ist == I_XMT) begin
          n.bf = 1'b0;
          n.dna = 1'b1;
          n.sda_lo = 1'b0;
        end else if (q.addr_ph && !match) begin
          n.ist = I_IDLE;
        end else if ((q.bf || q.ctl[OV_BIT]) && q.addr_ph) begin
          n.ctl[OV_BIT] = 1'b1;
        end else if (q.bf || q.ctl[OV_BIT]) begin
          n.ctl[OV_BIT] = 1'b1;
          n.dna = 1'b1;
        end else begin
          n.sbuf = q.rx;
          n.bf = 1'b1;
          n.sda_lo = 1'b1;
          n.dna = !q.addr_ph;
          if (q.addr_ph) begin
            n.ua = tenbit;
            n.addr2 = tenbit && !q.addr2 && !q.rx[0];
            n.addr_ph = n.addr2;
            if (!q.addr2) begin
              n.rnw = q.rx[0];
              n.ist = q.rx[0] ? I_XMT : I_RCV;
            end
          end
        end
      end else if (scl_f && q.ist != I_IDLE && q.bits == ACK_BIT) begin
        n.bits = 4'h0;
        n.sda_lo = 1'b0;
        n.rnw = 1'b0;
        if (q.ist == I_XMT) begin
          // hardware stretches clock for next byte
          n.ctl[CKP_BIT] = 1'b0;
        end
      end else if (scl_f && q.ist != I_IDLE) begin
        n.bits = q.bits + 4'h1;
        if (q.ist == I_XMT) begin
          n.sda_lo = !q.tx[7];
          n.tx = shl(q.tx, 1'b0);
        end
      end
    end
    if (!en) begin
      n.sta = 1'b0;
      n.stp = 1'b0;
      n.busy = 1'b0;
      n.pend = 1'b0;
      n.edges = 5'h00;
      n.bits = 4'h0;
      n.ist = I_IDLE;
      n.sda_lo = 1'b0;
      n.sck_lvl = q.ctl[CKP_BIT];
    end
    n.o_taken = en;
    n.o_sck = i2c ? 1'b0 : n.sck_lvl;
    // clock stretch while polarity bit clear
    n.o_sck_oe = en && (master || (i2c && !n.ctl[CKP_BIT]));
    n.o_sdo_oe = en && (master || (slave && slv_sel));
    n.o_sda_oe = en && i2c && n.sda_lo;
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end

  // outputs straight from the state record
  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign sck_o = q.o_sck;
  assign sck_oe_o = q.o_sck_oe;
  assign sdo_o = q.sdo;
  assign sdo_oe_o = q.o_sdo_oe;
  assign sda_o = q.o_sda;
  assign sda_oe_o = q.o_sda_oe;
  assign pins_taken_o = q.o_taken;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // bus ack is a single pulse
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  // idle spi master clock at polarity level
  idle_clock_a: assert property (
    (en && master && !q.busy && $stable(q.ctl))[*3] |-> sck_o == q.ctl[CKP_BIT])
    else $error("spi clock not at idle level");
  // clock never toggles on consecutive cycles, except in timer2 mode
  clk_rate_a: assert property (
    (master && q.busy && $changed(q.sck_lvl) && mode != M_TIMER2_OUTPUT) |=> $stable(q.sck_lvl))
    else $error("bit clock faster than divider allows");
  // overflow never raised by master transfer
  master_no_ov_a: assert property (
    (en && master && !wr) |=> !$rose(q.ctl[OV_BIT]))
    else $error("overflow set in master mode");
  // collision on busy buffer write
  write_collision_set_a: assert property (
    (bufwr && txbusy) |=> q.ctl[WRITE_COLLISION_BIT])
    else $error("write collision missed");
  // buffer read empties buffer
  bf_read_a: assert property (
    (rd && wb_i.adr == BUF_ADR && !done_m && !done_s && !i2c) |=> !q.bf)
    else $error("buffer full not cleared by read");
  // slave overflow keeps old byte
  ovf_keep_a: assert property (
    (done_s && q.bf && !wr) |=> q.ctl[OV_BIT] && q.sbuf == $past(q.sbuf))
    else $error("overflow byte not discarded");
  // start condition flags
  start_flag_a: assert property (
    (en && i2c && start_c && !wr) |=> q.sta && !q.stp)
    else $error("start not recorded");
  // stop condition flags
  stop_flag_a: assert property (
    (en && i2c && stop_c && !wr) |=> q.stp && !q.sta)
    else $error("stop not recorded");
  // disabled port shows no line state
  disable_clr_a: assert property (
    !en |=> !q.sta && !q.stp)
    else $error("start or stop kept while disabled");
  // clock stretching drives scl low
  stretch_hold_a: assert property (
    (en && i2c && !q.ctl[CKP_BIT] && !wr) |=> sck_oe_o && !sck_o)
    else $error("clock not stretched");
  // no acknowledge on overflowed address
  no_ack_a: assert property (
    (byte_end && q.addr_ph && q.ist == I_RCV && (q.bf || q.ctl[OV_BIT])) |=> !sda_oe_o)
    else $error("address acknowledged during overflow");
endmodule

// ===== dv/serial_peer.sv
// bus peer model: spi slave, spi master or i2c master facing the port
module serial_peer
  import ssp_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic [1:0] mode_i, // 0 spi slave, 1 spi master, 2 i2c
  input wire logic sck_i, // port clock pin level
  input wire logic sck_oe_i, // port clock drive enable
  input wire logic sdo_i, // port data out
  input wire logic sda_oe_i, // port pulls data low
  output pins_t pins_o // pin levels seen by the port
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  logic [7:0] cnt;
  logic prev_sck, msck, mss_n, msdi, msel, scl_m, sda_m, flip;
  initial begin
    tx_sh = 8'h00;
    rx_sh = 8'h00;
    cnt = 8'h00;
    {prev_sck, msck, msdi, msel, flip} = 5'h00;
    {mss_n, scl_m, sda_m} = 3'h7;
  end
  // shift under the port clock: sample on rise, next bit on fall
  always @(posedge clk_i) begin
    prev_sck <= sck_i;
    flip <= ~flip;
    if (mode_i == 2'h0 && sck_i && !prev_sck) begin
      rx_sh <= {rx_sh[6:0], sdo_i};
      cnt <= cnt + 8'h01;
    end
    if (mode_i == 2'h0 && !sck_i && prev_sck) tx_sh <= {tx_sh[6:0], tx_sh[0]};
  end
  // wire levels; an undriven data line toggles, i2c lines pulled up
  always_comb begin
    pins_o.ss_n = mss_n;
    pins_o.sdi = (mode_i == 2'h0) ? tx_sh[7] : (msel ? msdi : flip);
    pins_o.sck = (mode_i == 2'h1) ? msck : (mode_i == 2'h2) ? (scl_m & ~sck_oe_i) : sck_i;
    pins_o.sda = sda_m & ~sda_oe_i;
  end
  // one msb-first byte, 160 ns clock only inside the frame
  task automatic send(input logic [7:0] b, input logic use_ss);
    int i;
    #7;
    mss_n = ~use_ss;
    msel = 1'b1;
    for (i = 7; i >= 0; i--) begin
      msdi = b[i];
      #80 msck = 1'b1;
      #80 msck = 1'b0;
    end
    #80 mss_n = 1'b1;
    msel = 1'b0;
  endtask
  // data falls while clock high
  task automatic start_cond();
    #400 sda_m = 1'b0;
    #400 scl_m = 1'b0;
  endtask
  // data rises while clock high
  task automatic stop_cond();
    #400 sda_m = 1'b0;
    #400 scl_m = 1'b1;
    #400 sda_m = 1'b1;
    #400;
  endtask
endmodule

// ===== dv/sync_serial_port_ctrl_test.sv
// self-checking bench for the sync serial port controller
module sync_serial_port_ctrl_test
  import ssp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, wb_ack_o, timer2_tick_i, sck_o, sck_oe_o, sdo_o, sdo_oe_o;
  logic sda_o, sda_oe_o, pins_taken_o;
  logic [31:0] wb_dat_o;
  wb_req_t wb_i;
  pins_t pins_i;
  logic [1:0] peer_mode;
  logic [2:0] tick_cnt;
  logic [15:0] expq[$];
  logic [15:0] note;
  logic [7:0] b, t, c0;
  logic [3:0] m;
  int err_total, compares, seed;
  sync_serial_port_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .timer2_tick_i(timer2_tick_i), .pins_i(pins_i), .sck_o(sck_o),
    .sck_oe_o(sck_oe_o), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .pins_taken_o(pins_taken_o));
  serial_peer peer (.clk_i(clk_i), .mode_i(peer_mode), .sck_i(sck_o), .sck_oe_i(sck_oe_o),
    .sdo_i(sdo_o), .sda_oe_i(sda_oe_o), .pins_o(pins_i));
  // 50 mhz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // timer2 pulse every 8 cycles
  always @(posedge clk_i) begin
    tick_cnt <= tick_cnt + 3'h1;
    timer2_tick_i <= (tick_cnt == 3'h7);
  end
  task automatic print_verdict();
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] msk);
    if (msk != 8'h00) begin
      compares++;
      if ((got & msk) !== (exp & msk)) begin
        err_total++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task automatic check_pin(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t pin got=%h exp=%h", $time, got, exp);
    end
  endtask
  // classic single wishbone cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                    input logic [7:0] exp, input logic [7:0] msk, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h0, dat}};
    if (!we) expq.push_back({exp, msk});
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    rd = wb_dat_o[7:0];
    wb_i <= '0;
    if (n >= 40) begin
      err_total++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
    logic [7:0] r;
    wb(1'b1, adr, dat, 8'h00, 8'h00, r);
  endtask
  task automatic rdc(input logic [7:0] adr, input logic [7:0] exp, input logic [7:0] msk);
    logic [7:0] r;
    wb(1'b0, adr, 8'h00, exp, msk, r);
  endtask
  // poll status until buffer full
  task automatic wait_bf();
    logic [7:0] r;
    int n;
    n = 0;
    r = 8'h00;
    while (r[0] !== 1'b1 && n < 300) begin
      wb(1'b0, STAT_ADR, 8'h00, 8'h00, 8'h00, r);
      n++;
    end
    if (n >= 300) begin
      err_total++;
      print_verdict();
    end
  endtask
  // read data checked against the oldest note on each read ack
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_i.we === 1'b0 && expq.size() > 0) begin
      note = expq.pop_front();
      cmp_reg(wb_dat_o[7:0], note[15:8], note[7:0]);
    end
  end
  // main sequence
  initial begin
    rst_i = 1'b1;
    wb_i = '0;
    timer2_tick_i = 1'b0;
    tick_cnt = 3'h0;
    peer_mode = 2'h0;
    err_total = 0;
    compares = 0;
    seed = 32'h5730;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(CTRL_ADR, 8'h00, 8'hFF);
    rdc(STAT_ADR, 8'h00, 8'hFF);
    rdc(8'h55, 8'h00, 8'hFF);
    wr(STAT_ADR, 8'hFF);
    rdc(STAT_ADR, 8'hC0, 8'hFF);
    wr(STAT_ADR, 8'h00);
    wr(CTRL_ADR, 8'h31);
    repeat (4) @(posedge clk_i);
    check_pin(sck_o, 1'b1);
    check_pin(pins_taken_o, 1'b1);
    wr(CTRL_ADR, 8'h01);
    repeat (4) @(posedge clk_i);
    check_pin(pins_taken_o, 1'b0);
    for (m = 4'h0; m < 4'h4; m++) begin
      b = $random(seed);
      t = $random(seed);
      peer.tx_sh = t;
      wr(CTRL_ADR, {4'h2, m});
      c0 = peer.cnt;
      wr(BUF_ADR, b);
      wr(BUF_ADR, ~b);
      wait_bf();
      rdc(CTRL_ADR, 8'h80, 8'hC0);
      rdc(BUF_ADR, t, (m == 4'h0) ? 8'h00 : 8'hFF);
      cmp_reg(peer.rx_sh, b, 8'hFF);
      cmp_reg(peer.cnt - c0, 8'h08, 8'hFF);
      wr(IFLG_ADR, 8'h00);
      wr(CTRL_ADR, {4'h2, m});
      rdc(CTRL_ADR, 8'h00, 8'h80);
    end
    wr(BUF_ADR, b);
    wait_bf();
    // peer answers the second transfer with b, which must replace the unread byte
    peer.tx_sh = b;
    wr(BUF_ADR, t);
    repeat (200) @(posedge clk_i);
    rdc(CTRL_ADR, 8'h00, 8'h40);
    rdc(BUF_ADR, b, 8'hFF);
    wr(CTRL_ADR, 8'h24);
    peer_mode <= 2'h1;
    repeat (4) @(posedge clk_i);
    check_pin(sdo_oe_o, 1'b0);
    b = $random(seed);
    t = $random(seed);
    peer.send(b, 1'b1);
    wait_bf();
    peer.send(t, 1'b1);
    repeat (8) @(posedge clk_i);
    rdc(CTRL_ADR, 8'h40, 8'hC0);
    rdc(BUF_ADR, b, 8'hFF);
    rdc(STAT_ADR, 8'h00, 8'h01);
    wr(CTRL_ADR, 8'h25);
    rdc(CTRL_ADR, 8'h00, 8'h40);
    check_pin(sdo_oe_o, 1'b1);
    peer.send(t, 1'b0);
    wait_bf();
    rdc(BUF_ADR, t, 8'hFF);
    peer_mode <= 2'h2;
    wr(CTRL_ADR, 8'h3E);
    wr(IFLG_ADR, 8'h00);
    repeat (4) @(posedge clk_i);
    check_pin(sck_oe_o, 1'b0);
    wr(CTRL_ADR, 8'h2E);
    repeat (4) @(posedge clk_i);
    check_pin(sck_oe_o, 1'b1);
    wr(CTRL_ADR, 8'h3E);
    peer.start_cond();
    rdc(STAT_ADR, 8'h08, 8'h18);
    check_pin(sda_oe_o, 1'b0);
    rdc(IFLG_ADR, 8'h01, 8'h01);
    wr(IFLG_ADR, 8'h00);
    rdc(IFLG_ADR, 8'h00, 8'h01);
    peer.stop_cond();
    rdc(STAT_ADR, 8'h10, 8'h18);
    wr(CTRL_ADR, 8'h1E);
    rdc(STAT_ADR, 8'h00, 8'h18);
    print_verdict();
  end
endmodule
